// ===== adc_event_irq_enable_tb.sv
`timescale 1ns/100ps
`default_nettype none
`include "adcirq_consts.svh"

module adc_event_irq_enable_tb;
  logic              clock = 1'b0;
  logic              sys_rst = 1'b1;
  logic              awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic              awready, wready, bvalid, arready, rvalid, irq;
  logic [11:0]       awaddr = 12'h000, araddr = 12'h000;
  logic [31:0]       wdata = 32'h0, rdata;
  logic [3:0]        wstrb = 4'hf;
  logic [2:0]        prot = 3'h0, res_ch = 3'h0;
  logic [1:0]        bresp, rresp;
  logic [5:0]        evt = 6'h00;
  logic              res_vld = 1'b0;
  logic signed [15:0] res_val = 16'h0000;
  logic [7:0][15:0]  up_thr, lo_thr;
  int                failures = 0;
  int                n_tests = 0;

  always #2 clock = ~clock;

  adcirq_top i_adcirq_top (
    .clock(clock), .sys_rst(sys_rst),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_awaddr(awaddr),
    .s_axi_awprot(prot), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_bvalid(bvalid),
    .s_axi_bready(bready), .s_axi_bresp(bresp), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_araddr(araddr), .s_axi_arprot(prot),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .conv_started(evt[0]), .buffer_filled(evt[1]),
    .task_done(evt[2]), .result_ready(evt[3]), .offset_cal_complete(evt[4]),
    .conv_halted(evt[5]), .result_valid(res_vld), .result_channel(res_ch),
    .result_value(res_val), .channel_upper_threshold(up_thr),
    .channel_lower_threshold(lo_thr), .irq(irq)
  );

  task automatic chk_val(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      failures++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic chk_lvl(input logic exp);
    @(negedge clock);
    n_tests++;
    if (irq !== exp) begin
      failures++;
      $display("[FAIL] t=%0t irq=%h exp=%h", $time, irq, exp);
    end
  endtask

  // ready and valid are sampled mid-cycle, the handshake lands at the next rising edge
  task automatic axi_write(input logic [11:0] a, input logic [31:0] d, input logic [1:0] er);
    logic aw_t, w_t, b_t, done;
    logic [1:0] r;
    done = 1'b0;
    @(posedge clock);
    awvalid <= 1'b1;
    awaddr  <= a;
    wvalid  <= 1'b1;
    wdata   <= d;
    bready  <= 1'b1;
    while (!done) begin
      @(negedge clock);
      aw_t = awvalid & awready;
      w_t  = wvalid & wready;
      b_t  = bvalid & bready;
      r    = bresp;
      @(posedge clock);
      if (aw_t) awvalid <= 1'b0;
      if (w_t) wvalid <= 1'b0;
      if (b_t) begin
        bready <= 1'b0;
        done = 1'b1;
      end
    end
    chk_val({30'h0, r}, {30'h0, er});
  endtask

  task automatic axi_read(input logic [11:0] a, input logic [31:0] ed, input logic [1:0] er);
    logic ar_t, r_t, done;
    logic [31:0] d;
    logic [1:0] r;
    done = 1'b0;
    @(posedge clock);
    arvalid <= 1'b1;
    araddr  <= a;
    rready  <= 1'b1;
    while (!done) begin
      @(negedge clock);
      ar_t = arvalid & arready;
      r_t  = rvalid & rready;
      d    = rdata;
      r    = rresp;
      @(posedge clock);
      if (ar_t) arvalid <= 1'b0;
      if (r_t) begin
        rready <= 1'b0;
        done = 1'b1;
      end
    end
    chk_val(d, ed);
    chk_val({30'h0, r}, {30'h0, er});
  endtask

  task automatic pulse_evt(input int i);
    @(posedge clock);
    evt[i] <= 1'b1;
    @(posedge clock);
    evt[i] <= 1'b0;
  endtask

  task automatic send(input int ch, input logic [15:0] v);
    @(posedge clock);
    res_vld <= 1'b1;
    res_ch  <= 3'(ch);
    res_val <= v;
    @(posedge clock);
    res_vld <= 1'b0;
  endtask

  task automatic end_sim;
    $display("tests=%0d failures=%0d", n_tests, failures);
    if (failures == 0 && n_tests > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  initial begin
    repeat (20000) @(posedge clock);
    failures++;
    end_sim();
  end

  initial begin
    logic [11:0] ua;
    logic [11:0] la;
    logic [15:0] uv;
    logic [15:0] lv;
    for (int c = 0; c < 8; c++) begin
      up_thr[c] = 16'(16 * (c + 1));
      lo_thr[c] = 16'(-16 * (c + 1));
    end
    repeat (6) @(posedge clock);
    sys_rst <= 1'b0;
    chk_lvl(1'b0);
    axi_read(`ADCIRQ_MASK_OFS, 32'h0, `ADCIRQ_RESP_OKAY);
    for (int i = 0; i < 22; i++) begin
      axi_read(12'(`ADCIRQ_EVT_BASE + 4 * i), 32'h0, `ADCIRQ_RESP_OKAY);
    end
    axi_read(12'h200, 32'h0, `ADCIRQ_RESP_DECERR);
    axi_write(12'h204, 32'h1, `ADCIRQ_RESP_DECERR);
    axi_write(`ADCIRQ_MASK_OFS, 32'hffffffff, `ADCIRQ_RESP_OKAY);
    axi_read(`ADCIRQ_MASK_OFS, 32'h003fffff, `ADCIRQ_RESP_OKAY);
    axi_write(`ADCIRQ_MASK_OFS, 32'h0, `ADCIRQ_RESP_OKAY);
    // converter events: flag, gated irq, zero write clears
    for (int i = 0; i < 6; i++) begin
      ua = 12'(`ADCIRQ_EVT_BASE + 4 * i);
      pulse_evt(i);
      chk_lvl(1'b0);
      axi_read(ua, 32'h1, `ADCIRQ_RESP_OKAY);
      axi_write(`ADCIRQ_MASK_OFS, 32'h1 << i, `ADCIRQ_RESP_OKAY);
      chk_lvl(1'b1);
      axi_write(ua, 32'h0, `ADCIRQ_RESP_OKAY);
      chk_lvl(1'b0);
      pulse_evt(i);
      chk_lvl(1'b1);
      axi_write(`ADCIRQ_MASK_OFS, ~(32'h1 << i), `ADCIRQ_RESP_OKAY);
      chk_lvl(1'b0);
      axi_write(ua, 32'h0, `ADCIRQ_RESP_OKAY);
      axi_read(ua, 32'h0, `ADCIRQ_RESP_OKAY);
      axi_write(`ADCIRQ_MASK_OFS, 32'h0, `ADCIRQ_RESP_OKAY);
    end
    // halt held through a zero write: the set wins
    evt[5] <= 1'b1;
    axi_write(`ADCIRQ_STOPPED_OFS, 32'h0, `ADCIRQ_RESP_OKAY);
    evt[5] <= 1'b0;
    axi_read(`ADCIRQ_STOPPED_OFS, 32'h1, `ADCIRQ_RESP_OKAY);
    axi_write(`ADCIRQ_STOPPED_OFS, 32'h0, `ADCIRQ_RESP_OKAY);
    axi_read(`ADCIRQ_STOPPED_OFS, 32'h0, `ADCIRQ_RESP_OKAY);
    // limit events at the exact thresholds, one below the upper one first
    for (int c = 0; c < 8; c++) begin
      ua = 12'(`ADCIRQ_UPPER_OFS + `ADCIRQ_CH_STRIDE * c);
      la = 12'(`ADCIRQ_LOWER_OFS + `ADCIRQ_CH_STRIDE * c);
      uv = 16'(16 * (c + 1));
      lv = 16'(-16 * (c + 1));
      send(c, uv - 16'h0001);
      axi_read(ua, 32'h0, `ADCIRQ_RESP_OKAY);
      send(c, uv);
      axi_read(ua, 32'h1, `ADCIRQ_RESP_OKAY);
      axi_read(la, 32'h0, `ADCIRQ_RESP_OKAY);
      axi_write(`ADCIRQ_MASK_OFS, 32'h1 << (6 + 2 * c), `ADCIRQ_RESP_OKAY);
      chk_lvl(1'b1);
      axi_write(`ADCIRQ_MASK_OFS, 32'h1 << (7 + 2 * c), `ADCIRQ_RESP_OKAY);
      chk_lvl(1'b0);
      send(c, lv);
      axi_read(la, 32'h1, `ADCIRQ_RESP_OKAY);
      chk_lvl(1'b1);
      axi_write(`ADCIRQ_MASK_OFS, 32'h1 << (6 + 2 * c), `ADCIRQ_RESP_OKAY);
      axi_write(la, 32'h0, `ADCIRQ_RESP_OKAY);
      axi_write(ua, 32'h0, `ADCIRQ_RESP_OKAY);
      chk_lvl(1'b0);
      send(c, uv);
      chk_lvl(1'b1);
      axi_write(`ADCIRQ_MASK_OFS, 32'h0, `ADCIRQ_RESP_OKAY);
      axi_write(ua, 32'h0, `ADCIRQ_RESP_OKAY);
      axi_write(la, 32'h0, `ADCIRQ_RESP_OKAY);
      axi_read(ua, 32'h0, `ADCIRQ_RESP_OKAY);
    end
    // second reset with a pending enabled flag
    pulse_evt(5);
    axi_write(`ADCIRQ_MASK_OFS, 32'h20, `ADCIRQ_RESP_OKAY);
    chk_lvl(1'b1);
    @(posedge clock);
    sys_rst <= 1'b1;
    repeat (2) @(posedge clock);
    sys_rst <= 1'b0;
    chk_lvl(1'b0);
    axi_read(`ADCIRQ_MASK_OFS, 32'h0, `ADCIRQ_RESP_OKAY);
    axi_read(`ADCIRQ_STOPPED_OFS, 32'h0, `ADCIRQ_RESP_OKAY);
    end_sim();
  end
endmodule

`default_nettype wire

// ===== adcirq_consts.svh
`ifndef ADCIRQ_CONSTS_SVH
`define ADCIRQ_CONSTS_SVH

// register bus geometry
`define ADCIRQ_ADDR_W       12
`define ADCIRQ_DATA_W       32

// register offsets (byte addresses)
`define ADCIRQ_EVT_BASE     12'h100
`define ADCIRQ_STOPPED_OFS  12'h114
`define ADCIRQ_UPPER_OFS    12'h118
`define ADCIRQ_LOWER_OFS    12'h11c
`define ADCIRQ_CH_STRIDE    12'h008
`define ADCIRQ_MASK_OFS     12'h300

// reset values
`define ADCIRQ_EVT_RST      22'h000000
`define ADCIRQ_MASK_RST     22'h000000

// event and channel counts, field layout
`define ADCIRQ_NUM_EVT      22
`define ADCIRQ_NUM_CH       8
`define ADCIRQ_RES_W        16
`define ADCIRQ_IDX_STARTED  5'h00
`define ADCIRQ_IDX_FILLED   5'h01
`define ADCIRQ_IDX_DONE     5'h02
`define ADCIRQ_IDX_RESULT   5'h03
`define ADCIRQ_IDX_CAL      5'h04
`define ADCIRQ_IDX_STOPPED  5'h05
`define ADCIRQ_IDX_CH0_UP   5'h06
`define ADCIRQ_IDX_CH0_LO   5'h07
`define ADCIRQ_IDX_CH1_UP   5'h08
`define ADCIRQ_IDX_CH1_LO   5'h09

// bus answers
`define ADCIRQ_RESP_OKAY    2'h0
`define ADCIRQ_RESP_DECERR  2'h3

`endif

// ===== adcirq_limit_cmp.sv
`timescale 1ns/100ps
`default_nettype none

// signed compare of one result against a channel's limit pair
module adcirq_limit_cmp (
  // sample and limits
  input  wire logic signed [15:0] sample,
  input  wire logic signed [15:0] upper_limit,
  input  wire logic signed [15:0] lower_limit,
  // compare outcome
  output logic                    upper_threshold_hit,
  output logic                    lower_threshold_hit
);

  assign upper_threshold_hit = (sample >= upper_limit); // [R01]
  assign lower_threshold_hit = (sample <= lower_limit); // [R02]

endmodule

`default_nettype wire

// ===== adcirq_pkg.sv
package adcirq_pkg;

  typedef logic [21:0]        adcirq_evt_t;
  typedef logic [4:0]         adcirq_idx_t;
  typedef logic [2:0]         adcirq_chan_t;
  typedef logic signed [15:0] adcirq_sample_t;
  typedef logic [11:0]        adcirq_addr_t;

endpackage

// ===== adcirq_top.sv
// Operation
// R01: channel result at or above upper sets flag
// R02: channel result at or below lower sets flag
// R03: mask resets to zero, bit 0 gates started
// R04: mask bit 1 gates buffer filled
// R05: mask bit 2 gates conversion task done
// R06: mask bit 3 gates result ready
// R07: mask bit 4 gates offset calibration complete
// R08: mask bit 5 gates converter halted
// R09: mask bit 6 gates channel 0 upper hit
// R10: mask bit 7 gates channel 0 lower hit
// R11: mask bits 8, 9 gate channel 1 hits
// R12: halted flag set on stop, zero write clears
// R13: interrupt high while enabled flag is set
// R14: mask bits 10..21 gate channels 2..7 hits
//
// Chosen here: register access over AXI4-Lite.
`timescale 1ns/100ps
`default_nettype none
`include "adcirq_consts.svh"

module adcirq_top (
  // clock and reset
  input  wire logic                         clock,
  input  wire logic                         sys_rst,
  // axi4-lite write address
  input  wire logic                         s_axi_awvalid,
  output logic                              s_axi_awready,
  input  wire logic [11:0]                  s_axi_awaddr,
  input  wire logic [2:0]                   s_axi_awprot,
  // axi4-lite write data
  input  wire logic                         s_axi_wvalid,
  output logic                              s_axi_wready,
  input  wire logic [31:0]                  s_axi_wdata,
  input  wire logic [3:0]                   s_axi_wstrb,
  // axi4-lite write response
  output logic                              s_axi_bvalid,
  input  wire logic                         s_axi_bready,
  output logic [1:0]                        s_axi_bresp,
  // axi4-lite read address
  input  wire logic                         s_axi_arvalid,
  output logic                              s_axi_arready,
  input  wire logic [11:0]                  s_axi_araddr,
  input  wire logic [2:0]                   s_axi_arprot,
  // axi4-lite read data
  output logic                              s_axi_rvalid,
  input  wire logic                         s_axi_rready,
  output logic [31:0]                       s_axi_rdata,
  output logic [1:0]                        s_axi_rresp,
  // converter event pulses
  input  wire logic                         conv_started,
  input  wire logic                         buffer_filled,
  input  wire logic                         task_done,
  input  wire logic                         result_ready,
  input  wire logic                         offset_cal_complete,
  input  wire logic                         conv_halted,
  // latest result per conversion
  input  wire logic                         result_valid,
  input  wire logic [2:0]                   result_channel,
  input  wire logic signed [15:0]           result_value,
  // per-channel limits
  input  wire logic [7:0][15:0]             channel_upper_threshold,
  input  wire logic [7:0][15:0]             channel_lower_threshold,
  // interrupt
  output logic                              irq
);

  // address decode helpers
  function automatic logic evt_hit(input adcirq_pkg::adcirq_addr_t a);
    adcirq_pkg::adcirq_addr_t off;
    off     = a - `ADCIRQ_EVT_BASE;
    evt_hit = (a >= `ADCIRQ_EVT_BASE) && (a[1:0] == 2'h0)
              && (off[11:2] < 10'(`ADCIRQ_NUM_EVT));
  endfunction

  function automatic adcirq_pkg::adcirq_idx_t evt_idx(input adcirq_pkg::adcirq_addr_t a);
    adcirq_pkg::adcirq_addr_t off;
    off     = a - `ADCIRQ_EVT_BASE;
    evt_idx = off[6:2];
  endfunction

  function automatic adcirq_pkg::adcirq_idx_t lim_idx(input adcirq_pkg::adcirq_chan_t c,
                                                     input logic lower);
    adcirq_pkg::adcirq_addr_t ofs;
    ofs     = (lower ? `ADCIRQ_LOWER_OFS : `ADCIRQ_UPPER_OFS)
              + 12'({9'h000, c} * `ADCIRQ_CH_STRIDE);
    lim_idx = evt_idx(ofs);
  endfunction

  // write channel state
  logic                      aw_ok_ff;
  adcirq_pkg::adcirq_addr_t  awaddr_ff;
  logic                      w_ok_ff;
  logic [31:0]               wdata_ff;
  logic [3:0]                wstrb_ff;
  logic                      bvalid_ff;
  logic [1:0]                bresp_ff;
  // read channel state
  logic                      rvalid_ff;
  logic [31:0]               rdata_ff;
  logic [1:0]                rresp_ff;
  // block state
  adcirq_pkg::adcirq_evt_t   evt_ff;
  adcirq_pkg::adcirq_evt_t   mask_ff;

  // next values
  logic                      nxt_aw_ok_ff;
  logic                      nxt_w_ok_ff;
  logic                      nxt_bvalid_ff;
  logic                      nxt_rvalid_ff;
  adcirq_pkg::adcirq_evt_t   nxt_evt_ff;
  adcirq_pkg::adcirq_evt_t   nxt_mask_ff;

  // handshakes
  wire logic aw_take  = s_axi_awvalid & s_axi_awready;
  wire logic w_take   = s_axi_wvalid & s_axi_wready;
  wire logic ar_take  = s_axi_arvalid & s_axi_arready;
  wire logic wr_fire  = aw_ok_ff & w_ok_ff & ~bvalid_ff;

  // write decode
  wire logic                    wr_evt_hit  = evt_hit(awaddr_ff);
  wire adcirq_pkg::adcirq_idx_t wr_evt_idx  = evt_idx(awaddr_ff);
  wire logic                    wr_mask_hit = (awaddr_ff == `ADCIRQ_MASK_OFS);
  wire logic                    wr_mapped   = wr_evt_hit | wr_mask_hit;
  wire adcirq_pkg::adcirq_evt_t wr_evt_sel  =
    (wr_fire && wr_evt_hit && wstrb_ff[0]) ? (22'h000001 << wr_evt_idx) : 22'h000000;
  wire adcirq_pkg::adcirq_evt_t wr_byte_en  =
    {{6{wstrb_ff[2]}}, {8{wstrb_ff[1]}}, {8{wstrb_ff[0]}}};
  wire logic                    wr_mask_sel = wr_fire & wr_mask_hit;

  // read decode
  wire logic                    rd_evt_hit  = evt_hit(s_axi_araddr);
  wire adcirq_pkg::adcirq_idx_t rd_evt_idx  = evt_idx(s_axi_araddr);
  wire logic                    rd_mask_hit = (s_axi_araddr == `ADCIRQ_MASK_OFS);
  wire logic [31:0]             rd_data     =
    rd_evt_hit  ? {31'h00000000, evt_ff[rd_evt_idx]} :
    rd_mask_hit ? {10'h000, mask_ff} : 32'h00000000;
  wire logic [1:0]              rd_resp     =
    (rd_evt_hit | rd_mask_hit) ? `ADCIRQ_RESP_OKAY : `ADCIRQ_RESP_DECERR;

  // limit compare on the reporting channel
  logic                    up_hit;
  logic                    lo_hit;
  adcirq_limit_cmp u_cmp (
    .sample              (result_value),
    .upper_limit         (channel_upper_threshold[result_channel]),
    .lower_limit         (channel_lower_threshold[result_channel]),
    .upper_threshold_hit (up_hit),
    .lower_threshold_hit (lo_hit)
  );

  wire adcirq_pkg::adcirq_idx_t up_idx = lim_idx(result_channel, 1'b0);
  wire adcirq_pkg::adcirq_idx_t lo_idx = lim_idx(result_channel, 1'b1);
  wire adcirq_pkg::adcirq_evt_t up_set =
    (result_valid && up_hit) ? (22'h000001 << up_idx) : 22'h000000; // [R01]
  wire adcirq_pkg::adcirq_evt_t lo_set =
    (result_valid && lo_hit) ? (22'h000001 << lo_idx) : 22'h000000; // [R02]

  // hardware event sets, positions match the mask layout
  wire adcirq_pkg::adcirq_evt_t evt_set = up_set | lo_set
    | {16'h0000, conv_halted, offset_cal_complete, result_ready,
       task_done, buffer_filled, conv_started}; // [R12]

  // set wins over a same-cycle write of zero
  assign nxt_evt_ff  = evt_set
                     | (wr_evt_sel & {22{wdata_ff[0]}})
                     | (~wr_evt_sel & evt_ff); // [R01] [R02] [R12]
  assign nxt_mask_ff = wr_mask_sel
                     ? ((wdata_ff[21:0] & wr_byte_en) | (mask_ff & ~wr_byte_en))
                     : mask_ff;

  assign nxt_aw_ok_ff  = wr_fire ? 1'b0 : (aw_ok_ff | aw_take);
  assign nxt_w_ok_ff   = wr_fire ? 1'b0 : (w_ok_ff | w_take);
  assign nxt_bvalid_ff = wr_fire | (bvalid_ff & ~s_axi_bready);
  assign nxt_rvalid_ff = ar_take | (rvalid_ff & ~s_axi_rready);

  // block state
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      evt_ff  <= `ADCIRQ_EVT_RST;
      mask_ff <= `ADCIRQ_MASK_RST; // [R03]
    end else begin
      evt_ff  <= nxt_evt_ff;
      mask_ff <= nxt_mask_ff;
    end
  end

  // write channel
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      aw_ok_ff  <= 1'b0;
      w_ok_ff   <= 1'b0;
      bvalid_ff <= 1'b0;
    end else begin
      aw_ok_ff  <= nxt_aw_ok_ff;
      w_ok_ff   <= nxt_w_ok_ff;
      bvalid_ff <= nxt_bvalid_ff;
    end
  end

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      awaddr_ff <= 12'h000;
      wdata_ff  <= 32'h00000000;
      wstrb_ff  <= 4'h0;
      bresp_ff  <= `ADCIRQ_RESP_OKAY;
    end else begin
      if (aw_take) begin
        awaddr_ff <= s_axi_awaddr;
      end
      if (w_take) begin
        wdata_ff <= s_axi_wdata;
        wstrb_ff <= s_axi_wstrb;
      end
      if (wr_fire) begin
        bresp_ff <= wr_mapped ? `ADCIRQ_RESP_OKAY : `ADCIRQ_RESP_DECERR;
      end
    end
  end

  // read channel
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      rvalid_ff <= 1'b0;
      rdata_ff  <= 32'h00000000;
      rresp_ff  <= `ADCIRQ_RESP_OKAY;
    end else begin
      rvalid_ff <= nxt_rvalid_ff;
      if (ar_take) begin
        rdata_ff <= rd_data;
        rresp_ff <= rd_resp;
      end
    end
  end

  assign s_axi_awready = ~aw_ok_ff;
  assign s_axi_wready  = ~w_ok_ff;
  assign s_axi_bvalid  = bvalid_ff;
  assign s_axi_bresp   = bresp_ff;
  assign s_axi_arready = ~rvalid_ff;
  assign s_axi_rvalid  = rvalid_ff;
  assign s_axi_rdata   = rdata_ff;
  assign s_axi_rresp   = rresp_ff;

  // interrupt: any enabled flag
  assign irq = |(evt_ff & mask_ff); // [R04] [R05] [R06] [R07] [R08] [R09] [R10] [R11] [R13] [R14]

  // checks
  default clocking cb @(posedge clock); endclocking
  default disable iff (sys_rst);

  property p_upper_flag;
    (result_valid && up_hit) |=> evt_ff[$past(up_idx)];
  endproperty
  a_upper_flag: assert property (p_upper_flag) else $error("upper hit flag not set"); // [R01]

  property p_lower_flag;
    (result_valid && lo_hit) |=> evt_ff[$past(lo_idx)];
  endproperty
  a_lower_flag: assert property (p_lower_flag) else $error("lower hit flag not set"); // [R02]

  property p_mask_reset;
    @(posedge clock) disable iff (1'b0) sys_rst |=> (mask_ff == 22'h000000 && !irq);
  endproperty
  a_mask_reset: assert property (p_mask_reset) else $error("mask not cleared by reset"); // [R03]

  property p_started_irq;
    (conv_started && mask_ff[0] && !wr_mask_sel) |=> irq;
  endproperty
  a_started_irq: assert property (p_started_irq) else $error("started irq missing"); // [R03]

  property p_filled_irq;
    (buffer_filled && mask_ff[1] && !wr_mask_sel) |=> irq;
  endproperty
  a_filled_irq: assert property (p_filled_irq) else $error("filled irq missing"); // [R04]

  property p_done_irq;
    (task_done && mask_ff[2] && !wr_mask_sel) |=> irq;
  endproperty
  a_done_irq: assert property (p_done_irq) else $error("done irq missing"); // [R05]

  property p_result_irq;
    (result_ready && mask_ff[3] && !wr_mask_sel) |=> irq;
  endproperty
  a_result_irq: assert property (p_result_irq) else $error("result irq missing"); // [R06]

  property p_cal_irq;
    (offset_cal_complete && mask_ff[4] && !wr_mask_sel) |=> irq;
  endproperty
  a_cal_irq: assert property (p_cal_irq) else $error("calibration irq missing"); // [R07]

  property p_halt_irq;
    (conv_halted && mask_ff[5] && !wr_mask_sel) |=> irq;
  endproperty
  a_halt_irq: assert property (p_halt_irq) else $error("halt irq missing"); // [R08]

  property p_ch0_up_irq;
    (result_valid && up_hit && result_channel == 3'h0 && mask_ff[6] && !wr_mask_sel) |=> irq;
  endproperty
  a_ch0_up_irq: assert property (p_ch0_up_irq) else $error("ch0 upper irq missing"); // [R09]

  property p_ch0_lo_irq;
    (result_valid && lo_hit && result_channel == 3'h0 && mask_ff[7] && !wr_mask_sel) |=> irq;
  endproperty
  a_ch0_lo_irq: assert property (p_ch0_lo_irq) else $error("ch0 lower irq missing"); // [R10]

  property p_ch1_irq;
    (result_valid && result_channel == 3'h1 && !wr_mask_sel
     && ((up_hit && mask_ff[8]) || (lo_hit && mask_ff[9]))) |=> irq;
  endproperty
  a_ch1_irq: assert property (p_ch1_irq) else $error("ch1 irq missing"); // [R11]

  property p_halt_clear;
    (wr_evt_sel[5] && !wdata_ff[0] && !conv_halted) |=> !evt_ff[5];
  endproperty
  a_halt_clear: assert property (p_halt_clear) else $error("halted flag not cleared"); // [R12]

  property p_halt_set_wins;
    (conv_halted && wr_evt_sel[5]) |=> evt_ff[5] [*2] or (evt_ff[5] ##1 wr_evt_sel[5]);
  endproperty
  a_halt_set_wins: assert property (p_halt_set_wins) else $error("halt lost to clear"); // [R12]

  property p_irq_cause;
    irq |-> (evt_ff & mask_ff) != 22'h000000;
  endproperty
  a_irq_cause: assert property (p_irq_cause) else $error("irq without enabled flag"); // [R13]

  property p_masked_quiet;
    (mask_ff == 22'h000000 && !wr_mask_sel) |=> !irq;
  endproperty
  a_masked_quiet: assert property (p_masked_quiet) else $error("irq while fully masked"); // [R13]

  property p_upper_ch_irq;
    (result_valid && up_hit && result_channel >= 3'h2
     && mask_ff[$unsigned(up_idx)] && !wr_mask_sel) |=> irq;
  endproperty
  a_upper_ch_irq: assert property (p_upper_ch_irq) else $error("channel irq missing"); // [R14]

  property p_bresp_follows;
    wr_fire |=> s_axi_bvalid;
  endproperty
  a_bresp_follows: assert property (p_bresp_follows) else $error("write answer late");

  property p_rresp_follows;
    ar_take |=> s_axi_rvalid && s_axi_rdata == $past(rd_data);
  endproperty
  a_rresp_follows: assert property (p_rresp_follows) else $error("read answer wrong");

  c_mask_write:  cover property (wr_mask_sel && wdata_ff[21:0] != 22'h000000);
  c_halt_irq:    cover property (conv_halted && mask_ff[5] ##1 irq);
  c_ch7_lower:   cover property (result_valid && lo_hit && result_channel == 3'h7);
  c_set_vs_clr:  cover property (conv_halted && wr_evt_sel[5] && !wdata_ff[0]);

endmodule

`default_nettype wire
